// File: include/mdcfg_pkg.sv
// Package: register map, field positions, reset values and timing for the config bank
package mdcfg_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam logic [5:0] OFF_PWM_ONE = 6'h20;
    localparam logic [5:0] OFF_PWMG = 6'h1D;
    localparam logic [5:0] OFF_PREDRV = 6'h22;
    localparam logic [5:0] OFF_CSENSE = 6'h23;
    localparam logic [5:0] OFF_SYSCTL = 6'h3F;
    localparam int PARITY_BIT = 15;
    localparam int SYNC_ACC_LSB = 0;
    localparam int SSC_OFF_BIT = 2;
    localparam int DRIVE_LSB = 0;
    localparam int DLYCMP_BIT = 7;
    localparam int DEAD_LSB = 4;
    localparam int SLEW_LSB = 0;
    localparam int SAMP_ON_BIT = 3;
    localparam int GAIN_LSB = 0;
    localparam int KEY_LSB = 12;
    localparam int LOCK_BIT = 7;
    localparam int PARITY_ON_BIT = 6;
    localparam logic [2:0] WRITE_KEY_VAL = 3'h5;
    localparam logic [15:0] PWM_ONE_MASK = 16'h0007;
    localparam logic [15:0] PWMG_MASK = 16'h0003;
    localparam logic [15:0] PREDRV_MASK = 16'h0FF3;
    localparam logic [15:0] CSENSE_MASK = 16'h000B;
    localparam logic [15:0] SYSCTL_MASK = 16'h01FF;
    localparam logic [15:0] PWM_ONE_RST_HW = 16'h0004;
    localparam logic [15:0] PWM_ONE_RST_AD = 16'h0007;
    localparam logic [15:0] PREDRV_RST = 16'h0000;
    localparam logic [15:0] CSENSE_RST = 16'h0008;
    localparam logic [15:0] SYSCTL_RST = 16'h0000;
    localparam logic [15:0] PWMG_RST = 16'h0000;
    localparam logic [1:0] DRIVE_RST_HW = 2'h0;
    localparam logic [1:0] DRIVE_RST_AD = 2'h3;
    localparam int DEAD_STEP_NS = 200;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEAD_STEP_CYC = (DEAD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] SYNC_COUNT_0 = 10'h200;
    localparam logic [9:0] SYNC_COUNT_1 = 10'h100;
    localparam logic [9:0] SYNC_COUNT_2 = 10'h080;
    localparam logic [9:0] SYNC_COUNT_3 = 10'h040;
    typedef enum logic [1:0] {MDC_SIX_A, MDC_SIX_B, MDC_THREE, MDC_GEN} mdc_drive_t;
endpackage

// File: logic/mdcfg_dead_timer.sv
// Dead-time counter: cycles of insertion for the selected code
`timescale 1ns/1ps
`default_nettype none
module mdcfg_dead_timer (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [2:0] sel,
    input wire logic start,
    output logic busy
);
    localparam logic [11:0] STEP = 12'(mdcfg_pkg::DEAD_STEP_CYC);
    logic [11:0] cnt_reg;
    logic [11:0] cnt_next;
    wire logic [11:0] load_val = 12'(STEP * {9'h000, sel});
    // Code zero loads nothing: handshake only
    assign cnt_next = start ? load_val : (cnt_reg != 12'h000 ? cnt_reg - 12'h001 : 12'h000);
    assign busy = cnt_reg != 12'h000;
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            cnt_reg <= 12'h000;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule
`default_nettype wire

// File: logic/mdcfg_regs.sv
// Configuration register bank of the three-phase driver
// Notes on behaviour
// - Two-bit sync accuracy picks 512, 256, 128 or 64 serial clocks.
// - Bit 15 reads parity while parity is enabled, else zero.
// - Spread spectrum off bit resets to one, disabling modulation.
// - Drive scheme: 0/1 six-input, 2 three-input, 3 internal generation.
// - Drive scheme reset: 00 on hardware-serial, 11 on addressed variant.
// - Delay compensation bit enables compensation, resets to zero.
// - Dead time code 0 handshake only, else 200 ns steps.
// - Slew select chooses 35, 75, 180, 230 V/us, resets zero.
// - Sense amplifier enable bit, resets to one.
// - Sense gain select 0.25, 0.5, 1, 2 V/A, resets zero.
// - Lock bit locks configuration registers, resets zero.
// - Parity enable bit covers both serial interfaces, resets zero.
`timescale 1ns/1ps
`default_nettype none
module mdcfg_regs #(
    parameter bit ADDRESSED_VARIANT = 1'b1
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [5:0] ADDR,
    input wire logic [15:0] WDATA,
    output logic [15:0] RDATA,
    output logic RD_HIT,
    input wire logic SYNC_CLK_EDGE,
    input wire logic DEAD_START,
    output logic [1:0] OSC_SYNC_ACCURACY_SEL,
    output logic [9:0] OSC_SYNC_COUNT,
    output logic OSC_SYNC_DONE,
    output logic SPREAD_SPECTRUM_OFF,
    output logic [1:0] DRIVE_SCHEME_SEL,
    output logic DRIVE_SIX_INPUT,
    output logic DRIVE_THREE_INPUT,
    output logic DRIVE_PWM_GEN,
    output logic DELAY_COMP_ON,
    output logic [2:0] DEAD_TIME_SEL,
    output logic DEAD_TIME_ACTIVE,
    output logic [1:0] SLEW_RATE_SEL,
    output logic SENSE_AMP_ON,
    output logic [1:0] SENSE_AMP_GAIN_SEL,
    output logic REG_LOCKED,
    output logic FRAME_PARITY_ON
);
    logic [15:0] pwmg_reg;
    logic [15:0] pwm_one_reg;
    logic [15:0] predrv_reg;
    logic [15:0] csense_reg;
    logic [15:0] sysctl_reg;
    logic [15:0] rdata_reg;
    logic rd_hit_reg;
    logic [1:0] sync_s_reg;
    logic sync_prev_reg;
    logic [9:0] sync_cnt_reg;
    logic sync_done_reg;
    logic [15:0] pwm_one_next;
    logic [15:0] sysctl_next;

    // Parity over the 15 data bits gives even parity for the word
    function automatic logic [15:0] with_parity(input logic [15:0] val, input logic on);
        logic [15:0] r;
        r = val;
        r[mdcfg_pkg::PARITY_BIT] = on ? ^val[14:0] : 1'b0;
        return r;
    endfunction

    function automatic logic [9:0] sync_target(input logic [1:0] sel);
        logic [9:0] r;
        unique case (sel)
            2'h0: r = mdcfg_pkg::SYNC_COUNT_0;
            2'h1: r = mdcfg_pkg::SYNC_COUNT_1;
            2'h2: r = mdcfg_pkg::SYNC_COUNT_2;
            2'h3: r = mdcfg_pkg::SYNC_COUNT_3;
        endcase
        return r;
    endfunction

    wire logic locked = sysctl_reg[mdcfg_pkg::LOCK_BIT];
    wire logic parity_on = sysctl_reg[mdcfg_pkg::PARITY_ON_BIT];
    wire logic key_ok = WDATA[mdcfg_pkg::KEY_LSB +: 3] == mdcfg_pkg::WRITE_KEY_VAL;
    // Lock blocks config writes but never the keyed register itself
    wire logic cfg_wr_ok = WR_EN && !locked;
    wire logic wr_pwmg = cfg_wr_ok && ADDR == mdcfg_pkg::OFF_PWMG;
    wire logic wr_pwm_one = cfg_wr_ok && ADDR == mdcfg_pkg::OFF_PWM_ONE;
    wire logic wr_predrv = cfg_wr_ok && ADDR == mdcfg_pkg::OFF_PREDRV;
    wire logic wr_csense = cfg_wr_ok && ADDR == mdcfg_pkg::OFF_CSENSE;
    wire logic wr_sysctl = WR_EN && ADDR == mdcfg_pkg::OFF_SYSCTL && key_ok;
    wire logic [15:0] pwm_one_rst = ADDRESSED_VARIANT ?
        mdcfg_pkg::PWM_ONE_RST_AD : mdcfg_pkg::PWM_ONE_RST_HW;

    // Masks drop parity, reserved read-only bits and the key field
    assign pwm_one_next = WDATA & mdcfg_pkg::PWM_ONE_MASK;
    assign sysctl_next = WDATA & mdcfg_pkg::SYSCTL_MASK;

    wire logic addr_known = ADDR == mdcfg_pkg::OFF_PWMG || ADDR == mdcfg_pkg::OFF_PWM_ONE
        || ADDR == mdcfg_pkg::OFF_PREDRV || ADDR == mdcfg_pkg::OFF_CSENSE
        || ADDR == mdcfg_pkg::OFF_SYSCTL;
    wire logic [15:0] rd_mux =
        ADDR == mdcfg_pkg::OFF_PWMG ? pwmg_reg :
        ADDR == mdcfg_pkg::OFF_PWM_ONE ? pwm_one_reg :
        ADDR == mdcfg_pkg::OFF_PREDRV ? predrv_reg :
        ADDR == mdcfg_pkg::OFF_CSENSE ? csense_reg :
        ADDR == mdcfg_pkg::OFF_SYSCTL ? sysctl_reg : 16'h0000;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            pwmg_reg <= mdcfg_pkg::PWMG_RST;
            // Variant parameter picks the drive scheme code held under reset
            pwm_one_reg <= pwm_one_rst;
            predrv_reg <= mdcfg_pkg::PREDRV_RST;
            csense_reg <= mdcfg_pkg::CSENSE_RST;
            sysctl_reg <= mdcfg_pkg::SYSCTL_RST;
        end else begin
            if (wr_pwmg) begin
                pwmg_reg <= WDATA & mdcfg_pkg::PWMG_MASK;
            end
            if (wr_pwm_one) begin
                pwm_one_reg <= pwm_one_next;
            end
            if (wr_predrv) begin
                predrv_reg <= WDATA & mdcfg_pkg::PREDRV_MASK;
            end
            if (wr_csense) begin
                csense_reg <= WDATA & mdcfg_pkg::CSENSE_MASK;
            end
            if (wr_sysctl) begin
                sysctl_reg <= sysctl_next;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rdata_reg <= 16'h0000;
            rd_hit_reg <= 1'b0;
        end else begin
            rd_hit_reg <= RD_EN && addr_known;
            if (RD_EN) begin
                rdata_reg <= with_parity(rd_mux, parity_on);
            end
        end
    end
    assign RDATA = rdata_reg;
    assign RD_HIT = rd_hit_reg;

    // Serial clock edges counted for oscillator sync; pin sampled twice first
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            sync_s_reg <= 2'h0;
            sync_prev_reg <= 1'b0;
            sync_cnt_reg <= 10'h000;
            sync_done_reg <= 1'b0;
        end else begin
            sync_s_reg <= {sync_s_reg[0], SYNC_CLK_EDGE};
            sync_prev_reg <= sync_s_reg[1];
            if (sync_s_reg[1] && !sync_prev_reg && !sync_done_reg) begin
                sync_cnt_reg <= sync_cnt_reg + 10'h001;
                if (sync_cnt_reg + 10'h001 >= sync_target(pwmg_reg[mdcfg_pkg::SYNC_ACC_LSB +: 2]))
                    sync_done_reg <= 1'b1;
            end
        end
    end

    mdcfg_dead_timer u_dead (
        .CORE_CLK(CORE_CLK),
        .RST_N(RST_N),
        .sel(predrv_reg[mdcfg_pkg::DEAD_LSB +: 3]),
        .start(DEAD_START),
        .busy(DEAD_TIME_ACTIVE)
    );

    wire logic [1:0] drive_sel = pwm_one_reg[mdcfg_pkg::DRIVE_LSB +: 2];
    assign OSC_SYNC_ACCURACY_SEL = pwmg_reg[mdcfg_pkg::SYNC_ACC_LSB +: 2];
    assign OSC_SYNC_COUNT = sync_target(pwmg_reg[mdcfg_pkg::SYNC_ACC_LSB +: 2]);
    assign OSC_SYNC_DONE = sync_done_reg;
    assign SPREAD_SPECTRUM_OFF = pwm_one_reg[mdcfg_pkg::SSC_OFF_BIT];
    assign DRIVE_SCHEME_SEL = drive_sel;
    assign DRIVE_SIX_INPUT = drive_sel == 2'(mdcfg_pkg::MDC_SIX_A)
        || drive_sel == 2'(mdcfg_pkg::MDC_SIX_B);
    assign DRIVE_THREE_INPUT = drive_sel == 2'(mdcfg_pkg::MDC_THREE);
    assign DRIVE_PWM_GEN = drive_sel == 2'(mdcfg_pkg::MDC_GEN);
    assign DELAY_COMP_ON = predrv_reg[mdcfg_pkg::DLYCMP_BIT];
    assign DEAD_TIME_SEL = predrv_reg[mdcfg_pkg::DEAD_LSB +: 3];
    assign SLEW_RATE_SEL = predrv_reg[mdcfg_pkg::SLEW_LSB +: 2];
    assign SENSE_AMP_ON = csense_reg[mdcfg_pkg::SAMP_ON_BIT];
    assign SENSE_AMP_GAIN_SEL = csense_reg[mdcfg_pkg::GAIN_LSB +: 2];
    assign REG_LOCKED = locked;
    assign FRAME_PARITY_ON = parity_on;
endmodule
`default_nettype wire

// File: verif/mdcfg_props.sv
// Checker: port-level timing relations of the config bank
`timescale 1ns/1ps
`default_nettype none
module mdcfg_props (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [5:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic [15:0] RDATA,
    input wire logic RD_HIT,
    input wire logic DEAD_START,
    input wire logic SPREAD_SPECTRUM_OFF,
    input wire logic [1:0] DRIVE_SCHEME_SEL,
    input wire logic DRIVE_PWM_GEN,
    input wire logic DELAY_COMP_ON,
    input wire logic [2:0] DEAD_TIME_SEL,
    input wire logic DEAD_TIME_ACTIVE,
    input wire logic SENSE_AMP_ON,
    input wire logic REG_LOCKED,
    input wire logic FRAME_PARITY_ON
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    wire mapped = ADDR inside {6'h1D, 6'h20, 6'h22, 6'h23, 6'h3F};
    wire wr_pre = WR_EN && ADDR == 6'h22;
    wire wr_sys = WR_EN && ADDR == 6'h3F;
    wire key_ok = WDATA[14:12] == 3'h5;
    read_map_a: assert property (RD_EN |=> RD_HIT == $past(mapped) && (RD_HIT || RDATA == 16'h0000))
        else $error("read hit or unmapped data wrong");
    parity_bit_a: assert property (RD_HIT |-> RDATA[15] == ($past(FRAME_PARITY_ON) & ^RDATA[14:0]))
        else $error("read parity bit wrong");
    reset_vals_a: assert property ($rose(RST_N) |-> SPREAD_SPECTRUM_OFF && SENSE_AMP_ON && !REG_LOCKED
        && !FRAME_PARITY_ON && !DELAY_COMP_ON && DRIVE_SCHEME_SEL == 2'h3)
        else $error("reset values wrong");
    lock_hold_a: assert property (wr_pre && REG_LOCKED |=> $stable(DELAY_COMP_ON) && $stable(DEAD_TIME_SEL))
        else $error("locked register changed");
    bad_key_a: assert property (wr_sys && !key_ok |=> $stable(REG_LOCKED) && $stable(FRAME_PARITY_ON))
        else $error("write without key took effect");
    sys_write_a: assert property (wr_sys && key_ok |=> REG_LOCKED == $past(WDATA[7])
        && FRAME_PARITY_ON == $past(WDATA[6]))
        else $error("system control write lost");
    pre_write_a: assert property (wr_pre && !REG_LOCKED |=> DELAY_COMP_ON == $past(WDATA[7])
        && DEAD_TIME_SEL == $past(WDATA[6:4]))
        else $error("predriver write lost");
    dead_run_a: assert property (DEAD_START && !DEAD_TIME_ACTIVE && DEAD_TIME_SEL != 3'h0 |=> DEAD_TIME_ACTIVE [*8])
        else $error("dead time ended early");
    dead_none_a: assert property (DEAD_START && !DEAD_TIME_ACTIVE && DEAD_TIME_SEL == 3'h0 |=> !DEAD_TIME_ACTIVE)
        else $error("dead time for code zero");
    drive_gen_a: assert property (DRIVE_PWM_GEN == (DRIVE_SCHEME_SEL == 2'h3))
        else $error("drive decode wrong");
    cover property (RD_EN ##1 RD_HIT);
    cover property (wr_pre && REG_LOCKED);
    cover property ($rose(DEAD_TIME_ACTIVE));
endmodule
`default_nettype wire

// File: verif/mdcfg_host.sv
// Host model: register strobes and a serial clock gated to frames
`timescale 1ns/1ps
`default_nettype none
module mdcfg_host (
    input wire logic CORE_CLK,
    input wire logic sclk_run,
    output logic WR_EN = 1'b0,
    output logic RD_EN = 1'b0,
    output logic [5:0] ADDR = 6'h00,
    output logic [15:0] WDATA = 16'h0000,
    output logic SYNC_CLK_EDGE = 1'b0,
    output logic rd_done = 1'b0
);
    logic [1:0] div_reg = 2'h0;
    always @(posedge CORE_CLK) begin
        rd_done <= RD_EN;
        div_reg <= div_reg + 2'h1;
        // Pin rests low outside frames
        if (div_reg == 2'h3) SYNC_CLK_EDGE <= sclk_run & ~SYNC_CLK_EDGE;
    end
    task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d);
        @(posedge CORE_CLK) #1;
        WR_EN = w;
        RD_EN = ~w;
        ADDR = a;
        WDATA = d;
        @(posedge CORE_CLK) #1;
        WR_EN = 1'b0;
        RD_EN = 1'b0;
        // Released bus shows the inverse, never a stale copy
        ADDR = ~a;
        WDATA = ~d;
    endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Bench: readback, lock, parity, sync count and dead time
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [5:0] OFFS[5] = '{6'h1D, 6'h20, 6'h22, 6'h23, 6'h3F};
    localparam logic [15:0] RSTV[5] = '{16'h0000, 16'h0007, 16'h0000, 16'h0008, 16'h0000};
    localparam logic [15:0] MSKV[5] = '{16'h0003, 16'h0007, 16'h0FF3, 16'h000B, 16'h01FF};
    logic CORE_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic DEAD_START = 1'b0;
    logic sclk_run = 1'b0;
    logic par_on = 1'b0;
    logic [15:0] d;
    logic [16:0] e;
    logic [16:0] exp_q[$];
    int seed = 29;
    int n_mismatch = 0;
    int n_tests = 0;
    int cnt;
    wire logic WR_EN, RD_EN, SYNC_CLK_EDGE, rd_done, RD_HIT, OSC_SYNC_DONE, DEAD_TIME_ACTIVE;
    wire logic [5:0] ADDR;
    wire logic [15:0] WDATA, RDATA;
    wire logic [9:0] OSC_SYNC_COUNT;
    wire logic [1:0] OSC_SYNC_ACCURACY_SEL, DRIVE_SCHEME_SEL, SLEW_RATE_SEL, SENSE_AMP_GAIN_SEL;
    wire logic DRIVE_SIX_INPUT, DRIVE_THREE_INPUT, DRIVE_PWM_GEN, SPREAD_SPECTRUM_OFF, SENSE_AMP_ON;
    mdcfg_host host (.CORE_CLK, .sclk_run, .WR_EN, .RD_EN, .ADDR, .WDATA, .SYNC_CLK_EDGE, .rd_done);
    mdcfg_regs dut (.CORE_CLK, .RST_N, .WR_EN, .RD_EN, .ADDR, .WDATA, .RDATA, .RD_HIT,
        .SYNC_CLK_EDGE, .DEAD_START, .OSC_SYNC_ACCURACY_SEL, .OSC_SYNC_COUNT, .OSC_SYNC_DONE,
        .SPREAD_SPECTRUM_OFF, .DRIVE_SCHEME_SEL, .DRIVE_SIX_INPUT, .DRIVE_THREE_INPUT,
        .DRIVE_PWM_GEN, .DELAY_COMP_ON(), .DEAD_TIME_SEL(), .DEAD_TIME_ACTIVE, .SLEW_RATE_SEL,
        .SENSE_AMP_ON, .SENSE_AMP_GAIN_SEL, .REG_LOCKED(), .FRAME_PARITY_ON());
    initial forever #5 CORE_CLK = ~CORE_CLK;
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic hit, input logic [14:0] v);
        exp_q.push_back({hit, par_on & hit & ^v, v});
        host.xfer(1'b0, a, 16'h0000);
    endtask
    task automatic report_and_stop();
        $display("compared %0d, mismatched %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(negedge CORE_CLK) if (rd_done === 1'b1) begin
        e = exp_q.pop_front();
        chk({RD_HIT, RDATA}, e);
    end
    initial begin
        #100000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge CORE_CLK);
        #1 RST_N = 1'b1;
        for (int i = 0; i < 5; i++) rd(OFFS[i], 1'b1, RSTV[i][14:0]);
        rd(6'h10, 1'b0, 15'h0000);
        $display("test reset values done");
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 5; i++) begin
                d = 16'($random(seed));
                // Keep the bank unlocked here; the key goes in every system write
                if (i == 4) d = (d & 16'h013F) | 16'h5000 | {9'h000, p[0], 6'h00};
                host.xfer(1'b1, OFFS[i], d);
                if (i == 4) par_on = p[0];
                rd(OFFS[i], 1'b1, d[14:0] & MSKV[i][14:0]);
            end
        end
        $display("test random writes done");
        for (int c = 0; c < 4; c++) begin
            // Bit 2 follows c[0] and bit 3 c[1], so spread and amplifier bits toggle too
            d = 16'(c) | (16'(c) << 2);
            host.xfer(1'b1, 6'h1D, d);
            host.xfer(1'b1, 6'h20, d);
            host.xfer(1'b1, 6'h22, d);
            host.xfer(1'b1, 6'h23, d);
            @(negedge CORE_CLK);
            chk({7'h00, OSC_SYNC_COUNT}, 17'h00200 >> c);
            chk({4'h0, OSC_SYNC_ACCURACY_SEL, DRIVE_SCHEME_SEL,
                SLEW_RATE_SEL, SENSE_AMP_GAIN_SEL, DRIVE_SIX_INPUT, DRIVE_THREE_INPUT,
                DRIVE_PWM_GEN, SPREAD_SPECTRUM_OFF, SENSE_AMP_ON},
                {4'h0, d[1:0], d[1:0], d[1:0], d[1:0], c < 2, c == 2, c == 3, d[2], d[3]});
        end
        sclk_run = 1'b1;
        repeat (480) @(negedge CORE_CLK);
        chk({16'h0000, OSC_SYNC_DONE}, 17'h00000);
        repeat (600) @(negedge CORE_CLK);
        chk({16'h0000, OSC_SYNC_DONE}, 17'h00001);
        sclk_run = 1'b0;
        $display("test sync count done");
        for (int c = 0; c < 8; c++) begin
            host.xfer(1'b1, 6'h22, {9'h000, 3'(c), 4'h0});
            @(posedge CORE_CLK) #1 DEAD_START = 1'b1;
            @(posedge CORE_CLK) #1 DEAD_START = 1'b0;
            cnt = 0;
            repeat (200) begin
                @(negedge CORE_CLK);
                if (DEAD_TIME_ACTIVE === 1'b1) cnt++;
            end
            chk(17'(cnt), 17'(c * 20));
        end
        $display("test dead time done");
        host.xfer(1'b1, 6'h3F, 16'h5080);
        par_on = 1'b0;
        host.xfer(1'b1, 6'h22, 16'h0FF3);
        rd(6'h22, 1'b1, 15'h0070);
        host.xfer(1'b1, 6'h3F, 16'h3000);
        rd(6'h3F, 1'b1, 15'h0080);
        host.xfer(1'b1, 6'h3F, 16'h5000);
        host.xfer(1'b1, 6'h22, 16'h0083);
        rd(6'h22, 1'b1, 15'h0083);
        $display("test lock done");
        @(posedge CORE_CLK) #1 RST_N = 1'b0;
        repeat (2) @(posedge CORE_CLK);
        #1 RST_N = 1'b1;
        rd(6'h20, 1'b1, 15'h0007);
        repeat (2) @(negedge CORE_CLK);
        chk(17'(exp_q.size()), 17'h00000);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
bind mdcfg_regs mdcfg_props chk_i (.CORE_CLK, .RST_N, .WR_EN, .RD_EN, .ADDR, .WDATA, .RDATA,
    .RD_HIT, .DEAD_START, .SPREAD_SPECTRUM_OFF, .DRIVE_SCHEME_SEL, .DRIVE_PWM_GEN, .DELAY_COMP_ON,
    .DEAD_TIME_SEL, .DEAD_TIME_ACTIVE, .SENSE_AMP_ON, .REG_LOCKED, .FRAME_PARITY_ON);
`default_nettype wire
